// file: common/ifpb_defines.svh
`ifndef IFPB_DEFINES_SVH
`define IFPB_DEFINES_SVH

// ==================================================================
// Register word offsets (byte address = offset)
`define IFPB_OFF_MAIN 5'h00
`define IFPB_OFF_EDGE 5'h04
`define IFPB_OFF_EXT 5'h08
`define IFPB_OFF_FLGA 5'h0c
`define IFPB_OFF_FLGB 5'h10
`define IFPB_OFF_PRIO 5'h14

// ==================================================================
// Main control fields
`define IFPB_MAIN_GEN 7
`define IFPB_MAIN_LOWEN 6
`define IFPB_MAIN_T0EN 5
`define IFPB_MAIN_P0EN 4
`define IFPB_MAIN_PCEN 3
`define IFPB_MAIN_T0F 2
`define IFPB_MAIN_P0F 1
`define IFPB_MAIN_PCF 0

// Edge and priority control fields
`define IFPB_EDGE_PUDIS 7
`define IFPB_EDGE_SEL0 6
`define IFPB_EDGE_SEL1 5
`define IFPB_EDGE_SEL2 4
`define IFPB_EDGE_T0PRI 2
`define IFPB_EDGE_PCPRI 0

// External pin control fields
`define IFPB_EXT_P2PRI 7
`define IFPB_EXT_P1PRI 6
`define IFPB_EXT_P2EN 4
`define IFPB_EXT_P1EN 3
`define IFPB_EXT_P2F 1
`define IFPB_EXT_P1F 0

// Flag register A fields
`define IFPB_FA_PSP 7
`define IFPB_FA_RXF 5
`define IFPB_FA_TXE 4

// ==================================================================
// Reset values and implemented-bit masks
`define IFPB_RST_MAIN 8'h00
`define IFPB_RST_EDGE 8'hf5
`define IFPB_RST_EXT 8'hc0
`define IFPB_MASK_EDGE 8'hf5
`define IFPB_MASK_EXT 8'hdb
`define IFPB_MASK_FLGB 8'hcf
`define IFPB_MASK_FLGA 8'hcf

`endif

// file: common/ifpb_pkg.sv
package ifpb_pkg;
    typedef enum logic [1:0] {
        IFPB_IDLE,
        IFPB_ANSWER
    } ifpb_bus_t;
endpackage

// file: design/ifpb_bank.sv
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "ifpb_defines.svh"
// Notes on behaviour
// - Priority bits act only while priority levels enabled; else one vector.
// - With priorities, low global enable passes or blocks all low requests.
// - Timer0, pin 0 and port change enables gate their requests.
// - Timer0 overflow sets main flag bit 2; software clears it.
// - Upper port pin change sets flag bit 0; software clears it.
// - Port mismatch keeps setting the flag until the port is read.
// - Flags set on events regardless of any enable.
// - Pull-up disable bit 7 overrides latch-driven pull-ups.
// - Edge selects choose rising (1) or falling (0) for pins 0-2.
// - Timer0 and port change priority bits select high when 1.
// - Pin 2/1 priorities, enables and software-cleared flags in third reg.
// - Unimplemented positions read as zero.
// - Parallel port access sets flag A bit 7; absent on small parts.
// - Converter and sync serial completion flags, software cleared.
// - Receive flag read-only, follows receive buffer full.
// - Transmit flag read-only, follows transmit buffer empty.
// - Capture/compare A flag sets on capture or compare match.
// - Timer2 period match and timer1 overflow flags, software cleared.
// - Oscillator fail flag sets on clock failure switchover.
// - Comparator change and bus collision flags, software cleared.
// - Voltage detect and timer3 overflow flags, software cleared.
// - Capture/compare B flag sets on capture or compare match.
module ifpb_bank #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core-side event pulses
    input wire logic timer0Overflow,
    input wire logic timer1Overflow,
    input wire logic timer2PeriodMatch,
    input wire logic timer3Overflow,
    input wire logic captureEventA,
    input wire logic captureEventB,
    input wire logic converterDone,
    input wire logic syncSerialDone,
    input wire logic parallelPortAccess,
    input wire logic oscillatorFail,
    input wire logic comparatorChange,
    input wire logic busCollision,
    input wire logic voltageDetect,
    // Asynchronous serial buffer state
    input wire logic asyncReceiveFull,
    input wire logic asyncTransmitEmpty,
    // Pins
    input wire logic [2:0] extPins,
    input wire logic [3:0] upperPortPins,
    input wire logic upperPortRead,
    input wire logic [3:0] portLatch,
    // Outputs to core and pads
    output logic [3:0] pullupEnable,
    output logic highRequest,
    output logic lowRequest
);

    // ==================================================================
    // Bus handshake: one wait cycle, answer on second edge
    ifpb_pkg::ifpb_bus_t busState_reg;
    logic [7:0] mainReg_reg;
    logic [7:0] edgeReg_reg;
    logic [7:0] extReg_reg;
    logic [7:0] flagA_reg;
    logic [7:0] flagB_reg;
    logic prioEnable_reg;
    logic [2:0] extPrev_reg;
    logic [3:0] portSnap_reg;
    logic [31:0] readData_next;
    logic accept;
    logic wrMain;
    logic wrExt;
    logic wrFlagA;
    logic wrFlagB;
    logic [2:0] pinEdge;
    logic mismatch;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off, input logic lane);
        hit = (a == off) && lane;
    endfunction

    assign accept = (busState_reg == ifpb_pkg::IFPB_ANSWER);
    assign wrMain = accept && avs_write && hit(avs_address, `IFPB_OFF_MAIN, avs_byteenable[0]);
    assign wrExt = accept && avs_write && hit(avs_address, `IFPB_OFF_EXT, avs_byteenable[0]);
    assign wrFlagA = accept && avs_write && hit(avs_address, `IFPB_OFF_FLGA, avs_byteenable[0]);
    assign wrFlagB = accept && avs_write && hit(avs_address, `IFPB_OFF_FLGB, avs_byteenable[0]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_reg <= ifpb_pkg::IFPB_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (busState_reg)
                ifpb_pkg::IFPB_IDLE: begin
                    if (avs_read || avs_write) begin
                        busState_reg <= ifpb_pkg::IFPB_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                ifpb_pkg::IFPB_ANSWER: begin
                    busState_reg <= ifpb_pkg::IFPB_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    busState_reg <= ifpb_pkg::IFPB_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ==================================================================
    // Pin edge and port mismatch detection
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gEdge
            // Rising when select is 1, falling when 0
            assign pinEdge[gi] = edgeReg_reg[`IFPB_EDGE_SEL0 - gi]
                ? (extPins[gi] && !extPrev_reg[gi])
                : (!extPins[gi] && extPrev_reg[gi]);
        end
    endgenerate

    assign mismatch = (upperPortPins != portSnap_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extPrev_reg <= 3'h0;
            portSnap_reg <= 4'h0;
        end else begin
            extPrev_reg <= extPins;
            // Only a port read ends the mismatch
            if (upperPortRead) begin
                portSnap_reg <= upperPortPins;
            end
        end
    end

    // ==================================================================
    // Control and flag registers; sets beat clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mainReg_reg <= `IFPB_RST_MAIN;
        end else begin
            if (wrMain) begin
                mainReg_reg <= avs_writedata[7:0];
            end
            if (timer0Overflow) begin
                mainReg_reg[`IFPB_MAIN_T0F] <= 1'b1;
            end
            if (pinEdge[0]) begin
                mainReg_reg[`IFPB_MAIN_P0F] <= 1'b1;
            end
            if (mismatch) begin
                mainReg_reg[`IFPB_MAIN_PCF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edgeReg_reg <= `IFPB_RST_EDGE;
            prioEnable_reg <= 1'b0;
        end else if (accept && avs_write && avs_byteenable[0]) begin
            if (avs_address == 5'(`IFPB_OFF_EDGE)) begin
                edgeReg_reg <= avs_writedata[7:0] & `IFPB_MASK_EDGE;
            end
            if (avs_address == 5'(`IFPB_OFF_PRIO)) begin
                prioEnable_reg <= avs_writedata[0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extReg_reg <= `IFPB_RST_EXT;
        end else begin
            if (wrExt) begin
                extReg_reg <= avs_writedata[7:0] & `IFPB_MASK_EXT;
            end
            if (pinEdge[1]) begin
                extReg_reg[`IFPB_EXT_P1F] <= 1'b1;
            end
            if (pinEdge[2]) begin
                extReg_reg[`IFPB_EXT_P2F] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flagA_reg <= 8'h00;
        end else begin
            if (wrFlagA) begin
                flagA_reg <= avs_writedata[7:0] & `IFPB_MASK_FLGA;
            end
            if (parallelPortAccess && HAS_PARALLEL_PORT) begin
                flagA_reg[7] <= 1'b1;
            end
            if (converterDone) begin
                flagA_reg[6] <= 1'b1;
            end
            if (syncSerialDone) begin
                flagA_reg[3] <= 1'b1;
            end
            if (captureEventA) begin
                flagA_reg[2] <= 1'b1;
            end
            if (timer2PeriodMatch) begin
                flagA_reg[1] <= 1'b1;
            end
            if (timer1Overflow) begin
                flagA_reg[0] <= 1'b1;
            end
            if (!HAS_PARALLEL_PORT) begin
                flagA_reg[7] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flagB_reg <= 8'h00;
        end else begin
            if (wrFlagB) begin
                flagB_reg <= avs_writedata[7:0] & `IFPB_MASK_FLGB;
            end
            if (oscillatorFail) begin
                flagB_reg[7] <= 1'b1;
            end
            if (comparatorChange) begin
                flagB_reg[6] <= 1'b1;
            end
            if (busCollision) begin
                flagB_reg[3] <= 1'b1;
            end
            if (voltageDetect) begin
                flagB_reg[2] <= 1'b1;
            end
            if (timer3Overflow) begin
                flagB_reg[1] <= 1'b1;
            end
            if (captureEventB) begin
                flagB_reg[0] <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Read path; receive and transmit flags are live buffer state
    always_comb begin
        readData_next = 32'h0;
        case (avs_address)
            5'(`IFPB_OFF_MAIN): readData_next[7:0] = mainReg_reg;
            5'(`IFPB_OFF_EDGE): readData_next[7:0] = edgeReg_reg;
            5'(`IFPB_OFF_EXT): readData_next[7:0] = extReg_reg;
            5'(`IFPB_OFF_FLGA): begin
                readData_next[7:0] = flagA_reg;
                readData_next[`IFPB_FA_RXF] = asyncReceiveFull;
                readData_next[`IFPB_FA_TXE] = asyncTransmitEmpty;
            end
            5'(`IFPB_OFF_FLGB): readData_next[7:0] = flagB_reg;
            5'(`IFPB_OFF_PRIO): readData_next[0] = prioEnable_reg;
            default: readData_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0;
        end else if (busState_reg == ifpb_pkg::IFPB_IDLE && avs_read) begin
            avs_readdata <= readData_next;
        end
    end

    // ==================================================================
    // Request generation for the five sources handled here (timer0, port change, pins 0-2)
    logic t0Req;
    logic p0Req;
    logic pcReq;
    logic p1Req;
    logic p2Req;
    logic anyHigh;
    logic anyLow;
    assign t0Req = mainReg_reg[`IFPB_MAIN_T0F] && mainReg_reg[`IFPB_MAIN_T0EN];
    assign p0Req = mainReg_reg[`IFPB_MAIN_P0F] && mainReg_reg[`IFPB_MAIN_P0EN];
    assign pcReq = mainReg_reg[`IFPB_MAIN_PCF] && mainReg_reg[`IFPB_MAIN_PCEN];
    assign p1Req = extReg_reg[`IFPB_EXT_P1F] && extReg_reg[`IFPB_EXT_P1EN];
    assign p2Req = extReg_reg[`IFPB_EXT_P2F] && extReg_reg[`IFPB_EXT_P2EN];
    // Pin 0 is always high priority
    assign anyHigh = p0Req
        || (t0Req && edgeReg_reg[`IFPB_EDGE_T0PRI])
        || (pcReq && edgeReg_reg[`IFPB_EDGE_PCPRI])
        || (p1Req && extReg_reg[`IFPB_EXT_P1PRI])
        || (p2Req && extReg_reg[`IFPB_EXT_P2PRI]);
    assign anyLow = (t0Req && !edgeReg_reg[`IFPB_EDGE_T0PRI])
        || (pcReq && !edgeReg_reg[`IFPB_EDGE_PCPRI])
        || (p1Req && !extReg_reg[`IFPB_EXT_P1PRI])
        || (p2Req && !extReg_reg[`IFPB_EXT_P2PRI]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            highRequest <= 1'b0;
            lowRequest <= 1'b0;
        end else if (prioEnable_reg) begin
            highRequest <= anyHigh && mainReg_reg[`IFPB_MAIN_GEN];
            lowRequest <= anyLow && mainReg_reg[`IFPB_MAIN_LOWEN]
                && mainReg_reg[`IFPB_MAIN_GEN];
        end else begin
            // Single vector: priority bits ignored
            highRequest <= (anyHigh || anyLow) && mainReg_reg[`IFPB_MAIN_GEN];
            lowRequest <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pullupEnable <= 4'h0;
        end else begin
            pullupEnable <= edgeReg_reg[`IFPB_EDGE_PUDIS] ? 4'h0 : portLatch;
        end
    end

    // ==================================================================
    // Checks
    timer0_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        timer0Overflow |=> mainReg_reg[`IFPB_MAIN_T0F])
        else $error("timer0 flag not set");
    port_mismatch_a: assert property (@(posedge clk) disable iff (!arst_n)
        mismatch && !upperPortRead |=> mainReg_reg[`IFPB_MAIN_PCF])
        else $error("port change flag not held");
    compat_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        !prioEnable_reg |=> !lowRequest)
        else $error("low request in single vector mode");
    compat_vector_a: assert property (@(posedge clk) disable iff (!arst_n)
        !prioEnable_reg && mainReg_reg[`IFPB_MAIN_GEN] && (anyHigh || anyLow)
        |=> highRequest)
        else $error("single vector request missing");
    low_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        prioEnable_reg && !mainReg_reg[`IFPB_MAIN_LOWEN] |=> !lowRequest)
        else $error("low request while blocked");
    low_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
        prioEnable_reg && anyLow && mainReg_reg[`IFPB_MAIN_LOWEN]
        && mainReg_reg[`IFPB_MAIN_GEN] |=> lowRequest)
        else $error("low request not passed");
    pullup_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        edgeReg_reg[`IFPB_EDGE_PUDIS] |=> pullupEnable == 4'h0)
        else $error("pull-ups not disabled");
    pin_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
        edgeReg_reg[`IFPB_EDGE_SEL1] && $rose(extPins[1]) |=> extReg_reg[0])
        else $error("pin 1 rising edge missed");
    pin_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
        !edgeReg_reg[`IFPB_EDGE_SEL1] && $fell(extPins[1]) |=> extReg_reg[`IFPB_EXT_P1F])
        else $error("pin 1 falling edge missed");
    set_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
        wrFlagB && voltageDetect |=> flagB_reg[2])
        else $error("set lost to clear");
    unused_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        (flagB_reg[5:4] == 2'h0) && (extReg_reg[5] == 1'b0))
        else $error("unimplemented bit set");
    gate_en_a: assert property (@(posedge clk) disable iff (!arst_n)
        !mainReg_reg[`IFPB_MAIN_T0EN] && !mainReg_reg[`IFPB_MAIN_PCEN]
        && !mainReg_reg[`IFPB_MAIN_P0EN] && !p1Req && !p2Req |=> !highRequest)
        else $error("request with sources disabled");
endmodule

// file: testbench/ifpb_source_model.sv
`timescale 1ns/1ns
// ==============================================================
// Peripheral event sources, pins and core port reads
module ifpb_source_model (
    // Clock
    input wire logic clk,
    // Events and levels toward the bank
    output logic [12:0] ev,
    output logic rxFull,
    output logic txEmpty,
    output logic [2:0] pins,
    output logic [3:0] upper,
    output logic portRead,
    output logic [3:0] latch
);
    initial begin
        ev = 13'h0000;
        rxFull = 1'b0;
        txEmpty = 1'b0;
        pins = 3'h0;
        upper = 4'h0;
        portRead = 1'b0;
        latch = 4'h0;
    end

    // ==============================================================
    // Hold one event source high for n cycles
    task automatic hold(input int i, input int n);
        @(posedge clk);
        ev[i] <= 1'b1;
        repeat (n) @(posedge clk);
        ev[i] <= 1'b0;
    endtask

    // Core reads the port, which ends any mismatch
    task automatic read_port();
        @(posedge clk);
        portRead <= 1'b1;
        @(posedge clk);
        portRead <= 1'b0;
    endtask
endmodule

// file: testbench/test_interrupt_flag_enable_priority_bank.sv
`timescale 1ns/1ns
module test_interrupt_flag_enable_priority_bank;
    logic clk, arst_n, rd, wr, waitReq, portRead, rxFull, txEmpty, highReq, lowReq;
    logic [4:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be, upper, latch, pull;
    logic [12:0] ev;
    logic [2:0] pins;
    logic [7:0] q;
    int nErrors, checks;
    // Flag register and bit of each event source, in ev order
    localparam logic [4:0] EV_ADDR [13] = '{5'h00, 5'h0c, 5'h0c, 5'h10, 5'h0c, 5'h10,
        5'h0c, 5'h0c, 5'h0c, 5'h10, 5'h10, 5'h10, 5'h10};
    localparam int EV_BIT [13] = '{2, 0, 1, 1, 2, 0, 6, 3, 7, 7, 6, 3, 2};

    ifpb_bank dut (
        .clk(clk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .timer0Overflow(ev[0]), .timer1Overflow(ev[1]),
        .timer2PeriodMatch(ev[2]), .timer3Overflow(ev[3]), .captureEventA(ev[4]),
        .captureEventB(ev[5]), .converterDone(ev[6]), .syncSerialDone(ev[7]),
        .parallelPortAccess(ev[8]), .oscillatorFail(ev[9]), .comparatorChange(ev[10]),
        .busCollision(ev[11]), .voltageDetect(ev[12]), .asyncReceiveFull(rxFull),
        .asyncTransmitEmpty(txEmpty), .extPins(pins), .upperPortPins(upper),
        .upperPortRead(portRead), .portLatch(latch), .pullupEnable(pull),
        .highRequest(highReq), .lowRequest(lowReq)
    );

    ifpb_source_model src (.clk(clk), .ev(ev), .rxFull(rxFull), .txEmpty(txEmpty),
        .pins(pins), .upper(upper), .portRead(portRead), .latch(latch));

    // ==============================================================
    // Reporting and bus tasks
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
            input logic [3:0] b, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= {24'h000000, d};
        be <= b;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (waitReq !== 1'b0 && n < 20);
        r = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitReq !== 1'b0) begin
            nErrors++;
            $display("CHECK FAILED waitrequest expected 0 seen %b", waitReq);
            finish_test();
        end
    endtask

    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rdc(input string what, input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hf, q);
        check8(what, exp, q);
    endtask

    // Requests are registered one cycle after the enabling change
    task automatic reqs(input logic h, input logic l);
        repeat (3) @(posedge clk);
        check8("highRequest", {7'h00, h}, {7'h00, highReq});
        check8("lowRequest", {7'h00, l}, {7'h00, lowReq});
    endtask

    // ==============================================================
    // Scenarios
    task automatic test_reset();
        rdc("main", 5'h00, 8'h00);
        rdc("edge", 5'h04, 8'hf5);
        rdc("ext", 5'h08, 8'hc0);
        rdc("flagA", 5'h0c, 8'h00);
        rdc("flagB", 5'h10, 8'h00);
        rdc("prio", 5'h14, 8'h00);
        wr8(5'h18, 8'hff);
        rdc("unmapped", 5'h18, 8'h00);
        wr8(5'h04, 8'hff);
        rdc("edge", 5'h04, 8'hf5);
        wr8(5'h08, 8'hff);
        rdc("ext", 5'h08, 8'hdb);
        wr8(5'h10, 8'hff);
        rdc("flagB", 5'h10, 8'hcf);
        bus(1'b1, 5'h00, 8'hff, 4'he, q);
        rdc("main lane off", 5'h00, 8'h00);
        wr8(5'h08, 8'hc0);
        wr8(5'h10, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_events();
        for (int i = 0; i < 13; i++) begin
            src.hold(i, 1);
            rdc("event flag", EV_ADDR[i], 8'h01 << EV_BIT[i]);
            wr8(EV_ADDR[i], 8'h00);
            rdc("cleared flag", EV_ADDR[i], 8'h00);
        end
        // Event stays high only up to the edge at which the clear lands
        fork
            src.hold(0, 2);
            wr8(5'h00, 8'h00);
        join
        rdc("set beats clear", 5'h00, 8'h04);
        fork
            src.hold(12, 2);
            wr8(5'h10, 8'h00);
        join
        rdc("set beats clear B", 5'h10, 8'h04);
        wr8(5'h10, 8'h00);
        wr8(5'h00, 8'h00);
        $display("test events done");
    endtask

    task automatic test_serial();
        src.rxFull <= 1'b1;
        rdc("rx flag", 5'h0c, 8'h20);
        wr8(5'h0c, 8'h00);
        rdc("rx flag kept", 5'h0c, 8'h20);
        src.rxFull <= 1'b0;
        src.txEmpty <= 1'b1;
        wr8(5'h0c, 8'hff);
        rdc("tx flag", 5'h0c, 8'hdf);
        src.txEmpty <= 1'b0;
        wr8(5'h0c, 8'h00);
        rdc("flagA", 5'h0c, 8'h00);
        $display("test serial done");
    endtask

    task automatic test_port();
        src.upper <= 4'h5;
        rdc("port flag", 5'h00, 8'h01);
        wr8(5'h00, 8'h00);
        rdc("port flag held", 5'h00, 8'h01);
        src.read_port();
        wr8(5'h00, 8'h00);
        rdc("port flag cleared", 5'h00, 8'h00);
        $display("test port done");
    endtask

    task automatic test_requests();
        wr8(5'h00, 8'h00);
        src.hold(0, 1);
        wr8(5'h00, 8'h84);
        reqs(1'b0, 1'b0);
        wr8(5'h00, 8'ha4);
        reqs(1'b1, 1'b0);
        wr8(5'h04, 8'hf1);
        reqs(1'b1, 1'b0);
        wr8(5'h14, 8'h01);
        reqs(1'b0, 1'b0);
        wr8(5'h00, 8'he4);
        reqs(1'b0, 1'b1);
        wr8(5'h04, 8'hf5);
        reqs(1'b1, 1'b0);
        wr8(5'h00, 8'he0);
        reqs(1'b0, 1'b0);
        wr8(5'h14, 8'h00);
        wr8(5'h00, 8'h00);
        $display("test requests done");
    endtask

    task automatic test_pins();
        src.pins <= 3'b010;
        rdc("pin1 rise", 5'h08, 8'hc1);
        src.pins <= 3'b011;
        rdc("pin0 rise", 5'h00, 8'h02);
        wr8(5'h00, 8'h00);
        wr8(5'h08, 8'hc0);
        wr8(5'h04, 8'hd5);
        src.pins <= 3'b111;
        rdc("pin2 rise", 5'h08, 8'hc2);
        src.pins <= 3'b101;
        rdc("pin1 fall", 5'h08, 8'hc3);
        wr8(5'h14, 8'h01);
        wr8(5'h00, 8'h80);
        wr8(5'h08, 8'h89);
        reqs(1'b0, 1'b0);
        wr8(5'h00, 8'hc0);
        reqs(1'b0, 1'b1);
        wr8(5'h08, 8'hc9);
        reqs(1'b1, 1'b0);
        $display("test pins done");
    endtask

    task automatic test_pullups();
        src.latch <= 4'ha;
        repeat (3) @(posedge clk);
        check8("pullups off", 8'h00, {4'h0, pull});
        wr8(5'h04, 8'h75);
        repeat (3) @(posedge clk);
        check8("pullups latch", 8'h0a, {4'h0, pull});
        $display("test pullups done");
    endtask

    // ==============================================================
    // Clock, reset and sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 5'h00;
        wdata = 32'h00000000;
        be = 4'hf;
        nErrors = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        test_reset();
        test_events();
        test_serial();
        test_port();
        test_requests();
        test_pins();
        test_pullups();
        finish_test();
    end
endmodule
